// ### rtl/dacr_host.sv
`default_nettype none
module dacr_host
    import dacr_pkg::*;
#(
    parameter int unsigned WAKE_CYC = DACR_WAKE_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    dacr_if.host pins,
    input wire logic start_req,
    input wire logic want_shutdown,
    input wire logic pair_req,
    output logic ready,
    output logic [13:0] result_a,
    output logic [13:0] result_b,
    output logic result_valid
);
    typedef struct packed {
        dacr_hstate_t st;
        logic [1:0] busy_sync;
        logic busy_prev;
        logic [15:0] wait_cnt;
        logic [4:0] div_cnt;
        logic sclk;
        logic [4:0] bits;
        logic cs_n;
        logic cnv_n;
        logic [27:0] sh_a;
        logic [13:0] res_a;
        logic [13:0] res_b;
        logic valid;
        logic pair;
    } dacr_host_t;
    dacr_host_t cur_ff, nxt_ff;
    logic busy_s;
    assign busy_s = cur_ff.busy_sync[1];

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.busy_sync = {cur_ff.busy_sync[0], pins.busy};
        nxt_ff.busy_prev = busy_s;
        nxt_ff.valid = 1'b0;
        case (cur_ff.st)
            DACR_H_IDLE: begin
                nxt_ff.cnv_n = 1'b1;
                nxt_ff.wait_cnt = 16'h0000;
                nxt_ff.st = DACR_H_WAKE; // wake every time
            end
            DACR_H_WAKE: begin
                if (cur_ff.wait_cnt != 16'(WAKE_CYC))
                    nxt_ff.wait_cnt = cur_ff.wait_cnt + 16'h0001;
                else if (start_req) begin
                    nxt_ff.cnv_n = 1'b0;
                    nxt_ff.pair = pair_req;
                    nxt_ff.st = DACR_H_CONV;
                end
            end
            DACR_H_CONV: begin
                if (busy_s && !want_shutdown)
                    nxt_ff.cnv_n = 1'b1;
                if (cur_ff.busy_prev && !busy_s) begin // low kept for shutdown
                    nxt_ff.cs_n = 1'b0;
                    nxt_ff.div_cnt = 5'h00;
                    nxt_ff.bits = 5'h00;
                    nxt_ff.sclk = 1'b1;
                    nxt_ff.st = DACR_H_READ;
                end
            end
            DACR_H_READ: begin
                nxt_ff.div_cnt = cur_ff.div_cnt + 5'h01;
                if (cur_ff.div_cnt == DACR_SCLK_DIV) begin
                    nxt_ff.div_cnt = 5'h00;
                    nxt_ff.sclk = !cur_ff.sclk;
                    if (!cur_ff.sclk) begin
                        // sample on rising edge, after device shifted on falling
                        nxt_ff.sh_a = {cur_ff.sh_a[26:0], pins.serial_out_first_converter};
                        nxt_ff.bits = cur_ff.bits + 5'h01;
                        if (cur_ff.bits == DACR_LAST_BIT) begin
                            nxt_ff.cs_n = 1'b1;
                            nxt_ff.res_a = nxt_ff.sh_a[27:14];
                            nxt_ff.res_b = nxt_ff.sh_a[13:0]; // chained on one line
                            nxt_ff.valid = 1'b1;
                            nxt_ff.wait_cnt = 16'h0000;
                            nxt_ff.st = cur_ff.cnv_n ? DACR_H_WAKE : DACR_H_IDLE;
                        end
                    end
                end
            end
            default: nxt_ff.st = DACR_H_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cur_ff <= '0;
            cur_ff.st <= DACR_H_IDLE;
            cur_ff.cs_n <= 1'b1;
            cur_ff.cnv_n <= 1'b1;
            cur_ff.sclk <= 1'b1;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign pins.conversion_start_n = cur_ff.cnv_n;
    assign pins.cs_n = cur_ff.cs_n;
    assign pins.sclk = cur_ff.sclk;
    assign pins.pair_select = cur_ff.pair;
    assign ready = (cur_ff.st == DACR_H_WAKE) && (cur_ff.wait_cnt == 16'(WAKE_CYC));
    assign result_a = cur_ff.res_a;
    assign result_b = cur_ff.res_b;
    assign result_valid = cur_ff.valid;
endmodule : dacr_host
`default_nettype wire

// ### pkg/dacr_pkg.sv
`default_nettype none
package dacr_pkg;
    localparam int unsigned DACR_RES_BITS = 14;
    localparam int unsigned DACR_DUAL_BITS = 28;
    localparam logic [4:0] DACR_CNT_W0 = 5'h00;
    localparam logic [4:0] DACR_LAST_BIT = 5'h1b;
    localparam logic [4:0] DACR_FIRST_LAST = 5'h0d;
    // timing on the device side counts link-clock cycles (48 ns)
    localparam int unsigned DACR_LINK_NS = 48;
    localparam int unsigned DACR_MCLK_NS = 8;
    localparam int unsigned DACR_CONV_NS = 960;
    localparam int unsigned DACR_CONV_CYC = DACR_CONV_NS / DACR_LINK_NS;
    localparam int unsigned DACR_WAKE_US = 100;
    localparam int unsigned DACR_WAKE_CYC = (DACR_WAKE_US * 1000 + DACR_MCLK_NS - 1) / DACR_MCLK_NS;
    localparam int unsigned DACR_LEAD_NS = 96;
    localparam logic [13:0] DACR_RESULT_RST = 14'h0000;
    localparam logic [4:0] DACR_SCLK_DIV = 5'h02;
    typedef enum logic [3:0] {
        DACR_H_IDLE = 4'h1,
        DACR_H_WAKE = 4'h2,
        DACR_H_CONV = 4'h4,
        DACR_H_READ = 4'h8
    } dacr_hstate_t;
endpackage : dacr_pkg
`default_nettype wire

// ### pkg/dacr_if.sv
`default_nettype none
interface dacr_if;
    logic conversion_start_n;
    logic busy;
    logic cs_n;
    logic sclk;
    logic serial_out_first_converter;
    logic serial_out_second_converter;
    logic out_first_oe;
    logic out_second_oe;
    logic pair_select;
    modport dev (input conversion_start_n, input cs_n, input sclk, input pair_select,
        output busy, output serial_out_first_converter, output serial_out_second_converter,
        output out_first_oe, output out_second_oe);
    modport host (output conversion_start_n, output cs_n, output sclk, output pair_select,
        input busy, input serial_out_first_converter, input serial_out_second_converter,
        input out_first_oe, input out_second_oe);
endinterface : dacr_if
`default_nettype wire

// ### rtl/dacr_device.sv
`default_nettype none
module dacr_device
    import dacr_pkg::*;
#(
    parameter int unsigned CONV_CYC = DACR_CONV_CYC
) (
    input wire logic link_clk,
    input wire logic rst,
    dacr_if.dev pins,
    input wire logic [13:0] sample_a1,
    input wire logic [13:0] sample_a2,
    input wire logic [13:0] sample_b1,
    input wire logic [13:0] sample_b2,
    output logic powered_down
);
    // conversion timing runs on the internal oscillator, modelled by link_clk
    typedef struct packed {
        logic [1:0] st_sync;
        logic [1:0] pair_sync;
        logic st_prev;
        logic busy;
        logic [7:0] conv_cnt;
        logic pair;
        logic pair_next;
        logic shutdown;
        logic [13:0] res_a;
        logic [13:0] res_b;
    } dacr_dev_t;
    dacr_dev_t cur_ff, nxt_ff;
    logic st;

    assign st = cur_ff.st_sync[1];

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.st_sync = {cur_ff.st_sync[0], pins.conversion_start_n};
        // the select pin comes from the host's clock, so it is synchronised too
        nxt_ff.pair_sync = {cur_ff.pair_sync[0], pins.pair_select};
        nxt_ff.st_prev = st;
        if (!cur_ff.busy && cur_ff.st_prev && !st) begin
            nxt_ff.busy = 1'b1;
            nxt_ff.conv_cnt = 8'h00;
            nxt_ff.shutdown = 1'b0;
            nxt_ff.pair = cur_ff.pair_next;
            nxt_ff.pair_next = cur_ff.pair_sync[1];
        end else if (cur_ff.busy) begin
            nxt_ff.conv_cnt = cur_ff.conv_cnt + 8'h01;
            if (cur_ff.conv_cnt == 8'(CONV_CYC - 1)) begin
                nxt_ff.busy = 1'b0;
                // both channels of the selected pair latched in the same cycle, results kept as unsigned 14-bit values
                nxt_ff.res_a = cur_ff.pair ? sample_a2 : sample_a1;
                nxt_ff.res_b = cur_ff.pair ? sample_b2 : sample_b1;
                nxt_ff.shutdown = !st;
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (rst) begin
            cur_ff <= '0;
            cur_ff.st_sync <= 2'h3;
            cur_ff.st_prev <= 1'b1;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign pins.busy = cur_ff.busy;
    assign powered_down = cur_ff.shutdown; // results stay readable

    // serial side runs on host sclk falling edges, reset by select high
    logic [4:0] bit_ff;
    logic armed_ff;
    logic [27:0] shf_a_ff;
    logic [27:0] shf_b_ff;
    always_ff @(negedge pins.sclk or posedge pins.cs_n) begin
        if (pins.cs_n) begin
            bit_ff <= DACR_CNT_W0;
            armed_ff <= 1'b0;
            shf_a_ff <= '0;
            shf_b_ff <= '0;
        end else if (!armed_ff) begin
            // first edge after select falls: any edge coinciding is swallowed
            armed_ff <= 1'b1;
            shf_a_ff <= {cur_ff.res_a, cur_ff.res_b};
            shf_b_ff <= {cur_ff.res_b, cur_ff.res_a};
        end else if (bit_ff != DACR_LAST_BIT) begin
            bit_ff <= bit_ff + 5'h01;
            shf_a_ff <= {shf_a_ff[26:0], 1'b0};
            shf_b_ff <= {shf_b_ff[26:0], 1'b0};
        end
    end

    // before the first edge, the msb is shown straight from the held result
    assign pins.serial_out_first_converter = armed_ff ? shf_a_ff[27] : cur_ff.res_a[13];
    assign pins.serial_out_second_converter = armed_ff ? shf_b_ff[27] : cur_ff.res_b[13];
    assign pins.out_first_oe = !pins.cs_n;
    assign pins.out_second_oe = !pins.cs_n;
endmodule : dacr_device
`default_nettype wire

// ### verification/dacr_checker.sv
`default_nettype none
module dacr_checker #(
    parameter int unsigned WAKE_CYC = 20
) (
    input wire logic mclk,
    input wire logic link_clk,
    input wire logic rst,
    input wire logic conversion_start_n,
    input wire logic busy,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic out_first_oe,
    input wire logic out_second_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] high_ff;
    logic [5:0] falls_ff;
    always_ff @(posedge mclk) begin
        if (rst || !conversion_start_n) high_ff <= 16'h0000;
        else if (high_ff != 16'hffff) high_ff <= high_ff + 16'h0001;
        if (rst || cs_n) falls_ff <= 6'h00;
        else if ($fell(sclk)) falls_ff <= falls_ff + 6'h01;
    end
    oe_release_a: assert property (@(posedge mclk) disable iff (rst)
        cs_n |-> !out_first_oe && !out_second_oe) else $error("outputs driven with select high");
    start_busy_a: assert property (@(posedge link_clk) disable iff (rst)
        $fell(conversion_start_n) && !busy |-> ##[1:6] busy) else $error("busy did not rise");
    busy_hold_a: assert property (@(posedge link_clk) disable iff (rst)
        $rose(busy) |-> busy [*8]) else $error("busy dropped early");
    busy_end_a: assert property (@(posedge link_clk) disable iff (rst)
        $rose(busy) |-> ##[19:21] !busy) else $error("busy length wrong");
    // one cycle of slack for where the host starts its wait count
    wake_time_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(conversion_start_n) |-> high_ff >= WAKE_CYC - 1) else $error("wake too short");
    read_clocks_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(cs_n) |-> falls_ff >= 6'd14) else $error("too few serial clocks");
    start_quiet_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(conversion_start_n) |-> !busy) else $error("start during busy");
    sclk_idle_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(cs_n) |-> sclk) else $error("serial clock low at select fall");
endmodule // dacr_checker
`default_nettype wire

// ### verification/dacr_tb.sv
`default_nettype none
module dacr_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, link_clk, rst, start_req, want_shutdown, pair_req, ready, valid, pdown;
    logic [13:0] a1, a2, b1, b2, res_a, res_b;
    logic [27:0] sh_a, sh_b, exp;
    logic [31:0] seed;
    int fail_count, check_count, cycles;
    int nbits = 28;
    bit cur_pair, p;
    bit used_q[$];
    dacr_if pins_if();
    dacr_device #(.CONV_CYC(20)) dacr_device_inst (.link_clk(link_clk), .rst(rst),
        .pins(pins_if.dev), .sample_a1(a1), .sample_a2(a2), .sample_b1(b1),
        .sample_b2(b2), .powered_down(pdown));
    dacr_host #(.WAKE_CYC(20)) dacr_host_inst (.mclk(mclk), .rst(rst), .pins(pins_if.host),
        .start_req(start_req), .want_shutdown(want_shutdown), .pair_req(pair_req),
        .ready(ready), .result_a(res_a), .result_b(res_b), .result_valid(valid));
    dacr_checker #(.WAKE_CYC(20)) dacr_checker_inst (.mclk(mclk), .link_clk(link_clk),
        .rst(rst), .conversion_start_n(pins_if.conversion_start_n), .busy(pins_if.busy),
        .cs_n(pins_if.cs_n), .sclk(pins_if.sclk), .out_first_oe(pins_if.out_first_oe),
        .out_second_oe(pins_if.out_second_oe));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // odd offset keeps the link clock out of phase with mclk
    initial begin
        link_clk = 1'b0;
        #3;
        forever #24 link_clk = ~link_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [27:0] got, input logic [27:0] want);
        check_count++;
        if (got !== want) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic report_and_stop;
        if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    // the pair latched at busy rise serves the next conversion only
    always @(posedge pins_if.busy) begin
        used_q.push_back(cur_pair);
        cur_pair = pins_if.pair_select;
    end
    always @(negedge pins_if.busy) if (!rst) begin
        repeat (3) @(posedge link_clk);
        chk({27'h0, pdown}, {27'h0, want_shutdown});
    end
    always @(negedge pins_if.cs_n) begin
        sh_a = '0;
        sh_b = '0;
        nbits = 0;
    end
    // sample mid-bit on the rising edge; a bit count, not select, gates it because
    // select rises in the same time step as the last rising edge
    always @(posedge pins_if.sclk) if (nbits < 28) begin
        sh_a = {sh_a[26:0], pins_if.serial_out_first_converter};
        sh_b = {sh_b[26:0], pins_if.serial_out_second_converter};
        nbits++;
    end
    initial begin
        rst = 1'b1;
        {start_req, want_shutdown, pair_req, cur_pair} = '0;
        {a1, a2, b1, b2} = '0;
        seed = 32'd67630;
        repeat (16) @(posedge mclk);
        #1 rst = 1'b0;
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            {a1, a2} = seed[27:0];
            seed = xs(seed);
            {b1, b2} = seed[27:0];
            pair_req = seed[28];
            want_shutdown = seed[29];
            start_req = 1'b1;
            repeat (2000) begin
                @(posedge mclk);
                #1;
                if (valid === 1'b1) break;
            end
            start_req = 1'b0;
            p = used_q.pop_front();
            exp = p ? {a2, b2} : {a1, b1};
            chk({res_a, res_b}, exp);
            chk(sh_a, exp);
            chk({14'h0, sh_b[27:14]}, {14'h0, exp[13:0]});
        end
        report_and_stop();
    end
endmodule // dacr_tb
`default_nettype wire
